/* src/tdr_timers.sv */
// control, mode, clock-select and count registers of two counter/timers
`timescale 1ns/1ps
`default_nettype none
`include "tdr_map.svh"

module tdr_timers
  import tdr_pkg::*;
#(
  parameter int DIV_A   = `TDR_DIV_A,
  parameter int DIV_B   = `TDR_DIV_B,
  parameter int DIV_C   = `TDR_DIV_C,
  parameter int DIV_EXT = `TDR_DIV_EXT
) (
  input  wire logic       clk_in,              // system clock, 250 MHz
  input  wire logic       sys_rst_in,          // synchronous reset, active high
  input  wire logic [7:0] sfr_addr_in,         // register address
  input  wire logic       sfr_wr_in,           // write strobe
  input  wire logic [7:0] sfr_wdata_in,        // write data
  output logic      [7:0] sfr_rdata_out,       // read data, one cycle after address
  input  wire logic       ext_irq0_input_in,   // irq 0 pin
  input  wire logic       ext_irq1_input_in,   // irq 1 pin
  input  wire logic       irq0_polarity_in,    // 1 = irq 0 active high
  input  wire logic       irq1_polarity_in,    // 1 = irq 1 active high
  input  wire logic       count_pin_zero_in,   // timer 0 count pin
  input  wire logic       count_pin_one_in,    // timer 1 count pin
  input  wire logic       ext_clk_in,          // external oscillator pin
  input  wire logic       t0_vector_in,        // cpu vectors to timer 0 routine
  input  wire logic       t1_vector_in,        // cpu vectors to timer 1 routine
  input  wire logic       irq0_vector_in,      // cpu vectors to irq 0 routine
  input  wire logic       irq1_vector_in,      // cpu vectors to irq 1 routine
  input  wire logic       tmr2_split_in,       // timer 2 split mode
  input  wire logic       tmr2_alt_clk_sel_in, // timer 2 alternate clock select
  output logic            t0_overflow_flag_out, // timer 0 overflow flag
  output logic            t1_overflow_flag_out, // timer 1 overflow flag
  output logic            ext_irq0_flag_out,   // irq 0 flag
  output logic            ext_irq1_flag_out,   // irq 1 flag
  output logic            tmr2_high_tick_out,  // timer 2 high byte tick
  output logic            tmr2_low_tick_out    // timer 2 low byte tick
);

  // ==========================================================
  // parameters the counters cannot serve are refused
  if (DIV_C > 64 || DIV_C % DIV_A != 0 || DIV_C % DIV_B != 0 || DIV_A < 1 || DIV_B < 1)
    $error("prescale divisors do not fit the shared counter");
  if (DIV_EXT > 8 || DIV_EXT < 1)
    $error("external divisor does not fit its counter");

  tdr_state_t q;
  tdr_state_t n;
  logic       pin0_lvl;
  logic       pin1_lvl;
  logic       irq0_lvl;
  logic       irq1_lvl;
  logic       ext_lvl;

  // ==========================================================
  // every asynchronous input is filtered before use
  tdr_sync3 #(.INIT(1'b1)) u_pin0 (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_in(count_pin_zero_in), .lvl_out(pin0_lvl));
  tdr_sync3 #(.INIT(1'b1)) u_pin1 (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_in(count_pin_one_in), .lvl_out(pin1_lvl));
  tdr_sync3 #(.INIT(1'b1)) u_irq0 (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_in(ext_irq0_input_in), .lvl_out(irq0_lvl));
  tdr_sync3 #(.INIT(1'b1)) u_irq1 (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_in(ext_irq1_input_in), .lvl_out(irq1_lvl));
  tdr_sync3 #(.INIT(1'b0)) u_extc (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_in(ext_clk_in), .lvl_out(ext_lvl));

  // ==========================================================
  // one count step; returns {overflow, high, low}
  function automatic logic [16:0] tdr_step(input tdr_mode_t m, input logic [7:0] hi,
                                           input logic [7:0] lo);
    logic [16:0] r;
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0]  s8;
    r   = {1'b0, hi, lo};
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    s8  = {1'b0, lo} + 9'h001;
    case (m)
      TDR_MODE13:  r = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
      TDR_MODE16:  r = s16;
      TDR_RELOAD8: r = {s8[8], hi, (s8[8] ? hi : s8[7:0])};
      TDR_SPLIT8:  r = {s8[8], hi, s8[7:0]};
      default:     r = {1'b0, hi, lo};
    endcase
    return r;
  endfunction

  // ==========================================================
  // clock sources, ticks and enables
  logic      tick_a;
  logic      tick_b;
  logic      tick_c;
  logic      ext_fall;
  logic      tick_ext;
  logic      pre_tick;
  logic      tmr2_alt;
  logic      act0;
  logic      act1;
  logic      fall0;
  logic      fall1;
  logic      split;
  logic      en0;
  logic      en0h;
  logic      en1;
  tdr_mode_t m0;
  tdr_mode_t m1;

  assign tick_a   = (int'(q.pre_cnt) % DIV_A) == DIV_A - 1;
  assign tick_b   = (int'(q.pre_cnt) % DIV_B) == DIV_B - 1;
  assign tick_c   = int'(q.pre_cnt) == DIV_C - 1;
  assign ext_fall = q.ext_prev & ~ext_lvl;
  assign tick_ext = ext_fall & (int'(q.ext_div) == DIV_EXT - 1);

  // one shared prescaled tick for both timers
  always_comb begin
    case (q.clk_ctl[`TDR_CK_PREHI:`TDR_CK_PRELO])
      2'b00:   pre_tick = tick_a;
      2'b01:   pre_tick = tick_b;
      2'b10:   pre_tick = tick_c;
      default: pre_tick = tick_ext;
    endcase
  end

  assign tmr2_alt = tmr2_alt_clk_sel_in ? tick_ext : tick_a;
  // polarity 1 means the pin is active high
  assign act0  = ~(irq0_lvl ^ irq0_polarity_in);
  assign act1  = ~(irq1_lvl ^ irq1_polarity_in);
  assign fall0 = q.pin0_prev & ~pin0_lvl;
  assign fall1 = q.pin1_prev & ~pin1_lvl;
  assign m0    = tdr_mode_t'(q.mode_sel[`TDR_MS_M0HI:`TDR_MS_M0LO]);
  assign m1    = tdr_mode_t'(q.mode_sel[`TDR_MS_M1HI:`TDR_MS_M1LO]);
  assign split = m0 == TDR_SPLIT8;

  // timer 0: run bit, gate, then pin falls or selected clock
  assign en0 = q.ctl[`TDR_CTL_T0RUN] & (~q.mode_sel[`TDR_MS_T0_GATE_ENABLE] | act0)
             & (q.mode_sel[`TDR_MS_CNT0] ? fall0
                : (q.clk_ctl[`TDR_CK_T0SEL] | pre_tick));
  // split high byte is a plain timer on the timer 1 run bit
  assign en0h = split & q.ctl[`TDR_CTL_T1RUN]
              & (q.clk_ctl[`TDR_CK_T0SEL] | pre_tick);
  // while timer 0 is split, timer 1 runs by its mode alone and counts no pin
  assign en1 = (split ? 1'b1
                : q.ctl[`TDR_CTL_T1RUN] & (~q.mode_sel[`TDR_MS_T1_GATE_ENABLE] | act1))
             & (m1 != TDR_SPLIT8)
             & ((q.mode_sel[`TDR_MS_CNT1] & ~split) ? fall1
                : (q.clk_ctl[`TDR_CK_T1SEL] | pre_tick));

  // ==========================================================
  // next state: count, then software writes, then flag clears, then flag sets
  always_comb begin
    logic [16:0] r0;
    logic [16:0] r0h;
    logic [16:0] r1;
    logic        wr;
    n   = q;
    r0  = tdr_step(m0, q.tm0_hi, q.tm0_lo);
    r0h = tdr_step(TDR_SPLIT8, 8'h00, q.tm0_hi);
    r1  = tdr_step(m1, q.tm1_hi, q.tm1_lo);
    wr  = sfr_wr_in;

    // dividers for the prescaled and external clocks
    n.pre_cnt   = tick_c ? 6'h00 : q.pre_cnt + 6'h01;
    n.ext_prev  = ext_lvl;
    n.pin0_prev = pin0_lvl;
    n.pin1_prev = pin1_lvl;
    n.act0_prev = act0;
    n.act1_prev = act1;
    if (ext_fall) begin
      n.ext_div = tick_ext ? 3'h0 : q.ext_div + 3'h1;
    end

    // counting
    if (en0) begin
      n.tm0_lo = r0[7:0];
      if (!split) begin
        n.tm0_hi = r0[15:8];
      end
    end
    if (en0h) begin
      n.tm0_hi = r0h[7:0];
    end
    if (en1) begin
      n.tm1_hi = r1[15:8];
      n.tm1_lo = r1[7:0];
    end

    // software writes win over a count in the same cycle
    if (wr) begin
      case (sfr_addr_in)
        `TDR_ADDR_CTRL: n.ctl      = sfr_wdata_in;
        `TDR_ADDR_MODE: n.mode_sel = sfr_wdata_in;
        `TDR_ADDR_T0LO: n.tm0_lo   = sfr_wdata_in;
        `TDR_ADDR_T1LO: n.tm1_lo   = sfr_wdata_in;
        `TDR_ADDR_T0HI: n.tm0_hi   = sfr_wdata_in;
        `TDR_ADDR_T1HI: n.tm1_hi   = sfr_wdata_in;
        `TDR_ADDR_CLKC: n.clk_ctl  = sfr_wdata_in[5:0];
        default: ;
      endcase
    end

    // vectoring clears; irq flags only in edge mode
    if (t0_vector_in) n.ctl[`TDR_CTL_T0OVF] = 1'b0;
    if (t1_vector_in) n.ctl[`TDR_CTL_T1OVF] = 1'b0;
    if (irq0_vector_in && q.ctl[`TDR_CTL_IRQ0T]) n.ctl[`TDR_CTL_IRQ0F] = 1'b0;
    if (irq1_vector_in && q.ctl[`TDR_CTL_IRQ1T]) n.ctl[`TDR_CTL_IRQ1F] = 1'b0;

    // hardware sets come last so an event beats a clear in the same cycle
    if (en0 && r0[16]) n.ctl[`TDR_CTL_T0OVF] = 1'b1;
    if ((en0h && r0h[16]) || (en1 && r1[16] && !split)) begin
      n.ctl[`TDR_CTL_T1OVF] = 1'b1;
    end
    if (q.ctl[`TDR_CTL_IRQ0T] ? (act0 && !q.act0_prev) : act0) begin
      n.ctl[`TDR_CTL_IRQ0F] = 1'b1;
    end
    if (q.ctl[`TDR_CTL_IRQ1T] ? (act1 && !q.act1_prev) : act1) begin
      n.ctl[`TDR_CTL_IRQ1F] = 1'b1;
    end

    // timer 2 clock ticks; high byte select counts only when split
    n.t2l_tick = q.clk_ctl[`TDR_CK_T2L] | tmr2_alt;
    n.t2h_tick = tmr2_split_in ? (q.clk_ctl[`TDR_CK_T2H] | tmr2_alt)
               : (q.clk_ctl[`TDR_CK_T2L] | tmr2_alt);

    // read data registered from the address; unmapped reads give zero
    case (sfr_addr_in)
      `TDR_ADDR_CTRL: n.rdata = q.ctl;
      `TDR_ADDR_MODE: n.rdata = q.mode_sel;
      `TDR_ADDR_T0LO: n.rdata = q.tm0_lo;
      `TDR_ADDR_T1LO: n.rdata = q.tm1_lo;
      `TDR_ADDR_T0HI: n.rdata = q.tm0_hi;
      `TDR_ADDR_T1HI: n.rdata = q.tm1_hi;
      `TDR_ADDR_CLKC: n.rdata = {2'b00, q.clk_ctl};
      default:        n.rdata = 8'h00;
    endcase
  end

  // ==========================================================
  // state register; every register clears on reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign sfr_rdata_out        = q.rdata;
  assign t0_overflow_flag_out = q.ctl[`TDR_CTL_T0OVF];
  assign t1_overflow_flag_out = q.ctl[`TDR_CTL_T1OVF];
  assign ext_irq0_flag_out    = q.ctl[`TDR_CTL_IRQ0F];
  assign ext_irq1_flag_out    = q.ctl[`TDR_CTL_IRQ1F];
  assign tmr2_high_tick_out   = q.t2h_tick;
  assign tmr2_low_tick_out    = q.t2l_tick;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  // software writes legally override a count or a flag, so checks step aside for them
  logic wr_ctl;
  logic wr_t0;
  logic wr_t1;
  assign wr_ctl = sfr_wr_in && sfr_addr_in == `TDR_ADDR_CTRL;
  assign wr_t0  = sfr_wr_in && (sfr_addr_in == `TDR_ADDR_T0LO || sfr_addr_in == `TDR_ADDR_T0HI);
  assign wr_t1  = sfr_wr_in
                  && (sfr_addr_in == `TDR_ADDR_T1LO || sfr_addr_in == `TDR_ADDR_T1HI);

  chk_t1_ovf_set: assert property (
    en1 && !split && m1 == TDR_MODE16 && q.tm1_lo == 8'hff && q.tm1_hi == 8'hff && !wr_ctl
    && !wr_t1
    |=> t1_overflow_flag_out && q.tm1_lo == 8'h00 && q.tm1_hi == 8'h00)
    else $error("timer 1 wrap did not set its flag");
  chk_t0_mode13_wrap: assert property (
    en0 && m0 == TDR_MODE13 && q.tm0_hi == 8'hff && q.tm0_lo[4:0] == 5'h1f && !wr_ctl && !wr_t0
    |=> t0_overflow_flag_out && q.tm0_hi == 8'h00 && q.tm0_lo[4:0] == 5'h00)
    else $error("13-bit wrap wrong");
  chk_t0_run_off: assert property (
    !q.ctl[`TDR_CTL_T0RUN] && !wr_t0 |=> $stable(q.tm0_lo))
    else $error("timer 0 counted while stopped");
  chk_gate_blocks: assert property (
    q.mode_sel[`TDR_MS_T0_GATE_ENABLE] && !act0 && !wr_t0 |=> q.tm0_lo == $past(q.tm0_lo))
    else $error("gate did not hold timer 0");
  chk_reload_low: assert property (
    en0 && m0 == TDR_RELOAD8 && q.tm0_lo == 8'hff && !wr_t0 && !wr_ctl
    |=> q.tm0_lo == $past(q.tm0_hi) && t0_overflow_flag_out)
    else $error("reload from high byte missed");
  chk_irq1_level: assert property (
    !q.ctl[`TDR_CTL_IRQ1T] && act1 |=> ext_irq1_flag_out)
    else $error("level irq 1 flag not held");
  chk_irq0_vec_clr: assert property (
    q.ctl[`TDR_CTL_IRQ0T] && irq0_vector_in && !(act0 && !q.act0_prev) && !wr_ctl
    |=> !ext_irq0_flag_out)
    else $error("edge irq 0 flag not cleared on vector");
  chk_clk_top_zero: assert property (
    sfr_addr_in == `TDR_ADDR_CLKC |=> sfr_rdata_out[7:6] == 2'b00)
    else $error("clock control top bits not zero");
  chk_pin_fall_count: assert property (
    q.ctl[`TDR_CTL_T0RUN] && !q.mode_sel[`TDR_MS_T0_GATE_ENABLE] && q.mode_sel[`TDR_MS_CNT0]
    && m0 == TDR_MODE16 && !wr_t0 && !fall0 |=> $stable(q.tm0_lo))
    else $error("counter moved without a pin fall");
  chk_split_no_t1: assert property (
    split && !en0h && !wr_ctl && !t1_overflow_flag_out |=> !t1_overflow_flag_out)
    else $error("timer 1 flag set by timer 1 while timer 0 split");

  cov_split_high: cover property (en0h && q.tm0_hi == 8'hff);
  cov_reload: cover property (en0 && m0 == TDR_RELOAD8 && q.tm0_lo == 8'hff);
  cov_t1_wrap: cover property (en1 && !split && q.tm1_lo == 8'hff && q.tm1_hi == 8'hff);
  cov_ext_tick: cover property (tick_ext && q.clk_ctl[1:0] == 2'b11 && en0);
  cov_irq_edge: cover property (q.ctl[`TDR_CTL_IRQ1T] && act1 && !q.act1_prev);

endmodule

`default_nettype wire

/* src/tdr_map.svh */
// register offsets, field positions, reset values and divider counts of the timer block
`ifndef TDR_MAP_SVH
`define TDR_MAP_SVH

// ==========================================================
// register offsets in the special-function space
`define TDR_ADDR_CTRL   8'h88
`define TDR_ADDR_MODE   8'h89
`define TDR_ADDR_T0LO   8'h8a
`define TDR_ADDR_T1LO   8'h8b
`define TDR_ADDR_T0HI   8'h8c
`define TDR_ADDR_T1HI   8'h8d
`define TDR_ADDR_CLKC   8'h8e

// ==========================================================
// timer_control_status fields
`define TDR_CTL_T1OVF   7
`define TDR_CTL_T1RUN   6
`define TDR_CTL_T0OVF   5
`define TDR_CTL_T0RUN   4
`define TDR_CTL_IRQ1F   3
`define TDR_CTL_IRQ1T   2
`define TDR_CTL_IRQ0F   1
`define TDR_CTL_IRQ0T   0

// ==========================================================
// timer_mode_select fields
`define TDR_MS_T1_GATE_ENABLE    7
`define TDR_MS_CNT1     6
`define TDR_MS_M1HI     5
`define TDR_MS_M1LO     4
`define TDR_MS_T0_GATE_ENABLE    3
`define TDR_MS_CNT0     2
`define TDR_MS_M0HI     1
`define TDR_MS_M0LO     0

// ==========================================================
// clock_prescale_control fields
`define TDR_CK_T2H      5
`define TDR_CK_T2L      4
`define TDR_CK_T1SEL    3
`define TDR_CK_T0SEL    2
`define TDR_CK_PREHI    1
`define TDR_CK_PRELO    0

// ==========================================================
// reset values and divider counts
`define TDR_RST_BYTE    8'h00
`define TDR_DIV_A       12
`define TDR_DIV_B       4
`define TDR_DIV_C       48
`define TDR_DIV_EXT     8

`endif

/* src/tdr_pkg.sv */
// types shared by the timer control block and its pin synchroniser
package tdr_pkg;

  // ==========================================================
  // operating modes of a timer
  typedef enum logic [1:0] {
    TDR_MODE13,
    TDR_MODE16,
    TDR_RELOAD8,
    TDR_SPLIT8
  } tdr_mode_t;

  // ==========================================================
  // state of the pin synchroniser
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } tdr_sync_t;

  // ==========================================================
  // state of the timer control block
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] mode_sel;
    logic [7:0] tm0_lo;
    logic [7:0] tm0_hi;
    logic [7:0] tm1_lo;
    logic [7:0] tm1_hi;
    logic [5:0] clk_ctl;
    logic [5:0] pre_cnt;
    logic [2:0] ext_div;
    logic       ext_prev;
    logic       pin0_prev;
    logic       pin1_prev;
    logic       act0_prev;
    logic       act1_prev;
    logic [7:0] rdata;
    logic       t2h_tick;
    logic       t2l_tick;
  } tdr_state_t;

endpackage

/* src/tdr_sync3.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module tdr_sync3
  import tdr_pkg::*;
#(
  parameter logic INIT = 1'b1
) (
  input  wire logic clk_in,      // system clock
  input  wire logic sys_rst_in,  // synchronous reset, active high
  input  wire logic pin_in,      // asynchronous pin
  output logic      lvl_out      // filtered level
);

  tdr_sync_t q;
  tdr_sync_t n;

  // ==========================================================
  // the first stage feeds only the second; the level moves once stages two and three agree
  always_comb begin
    n = q;
    n.s1 = pin_in;
    n.s2 = q.s1;
    n.s3 = q.s2;
    if (q.s2 == q.s3) begin
      n.lvl = q.s3;
    end
  end

  // idle pins sit at INIT so no false edge follows reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      q <= '{s1: INIT, s2: INIT, s3: INIT, lvl: INIT};
    end else begin
      q <= n;
    end
  end

  assign lvl_out = q.lvl;

endmodule

`default_nettype wire

/* verif/tdr_far_model.sv */
// far-side model: cpu vector acknowledges, irq pins, count pins and external oscillator
`timescale 1ns/1ps
`default_nettype none

module tdr_far_model (
  input  wire logic       clk_in,   // system clock
  output logic      [1:0] irq_out,  // irq pins 1:0
  output logic      [1:0] cnt_out,  // count pins 1:0
  output logic      [3:0] vec_out,  // vectors: irq1, irq0, timer 1, timer 0
  output logic            osc_out   // free-running external oscillator
);
  // pins idle high, as after reset; vectors idle low
  initial begin
    irq_out = 2'b11;
    cnt_out = 2'b11;
    vec_out = 4'h0;
    osc_out = 1'b0;
    // oscillator runs free with a 24 ns period: each level spans three system clocks,
    // so the agreement filter always passes it
    #1.3;
    forever #12 osc_out = ~osc_out;
  end

  // level change on an irq pin, made just after an edge
  task automatic set_irq(input int idx, input logic v);
    @(posedge clk_in);
    irq_out[idx] <= v;
  endtask

  // n falling transitions, each level held hold cycles, never under two
  task automatic pulse(input int idx, input int n, input int hold);
    int h;
    h = (hold < 2) ? 2 : hold;
    repeat (n) begin
      @(posedge clk_in);
      cnt_out[idx] <= 1'b0;
      repeat (h) @(posedge clk_in);
      cnt_out[idx] <= 1'b1;
      repeat (h - 1) @(posedge clk_in);
    end
  endtask

  // cpu vectors after dly cycles: one-cycle acknowledge pulse
  task automatic vector(input int idx, input int dly);
    repeat (dly) @(posedge clk_in);
    vec_out[idx] <= 1'b1;
    @(posedge clk_in);
    vec_out[idx] <= 1'b0;
  endtask
endmodule

`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for the timer control block
`timescale 1ns/1ps
`default_nettype none
`include "tdr_map.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end

module tb_top;
  logic       clk_in     = 1'b0;
  logic       sys_rst_in = 1'b1;
  logic [7:0] addr       = 8'h00;
  logic       wr         = 1'b0;
  logic [7:0] wdata      = 8'h00;
  logic [1:0] pol        = 2'b00;
  logic [1:0] t2c        = 2'b00; // timer 2 split, alternate clock select
  logic [7:0] rdata, d, a;
  logic [1:0] irq, cnt, flg_t, flg_i;
  logic [3:0] vec;
  logic       osc, t2h, t2l;
  int         n_fail = 0, check_count = 0, cyc = 0, i, t;
  // 961 cycles over 12, 4 and 48; 3844 ns over 8 oscillator periods of 24 ns
  int         exp_cnt[4] = '{80, 240, 20, 20};

  // ==========================================================
  // clock, design and far side
  initial begin
    forever #2 clk_in = ~clk_in;
  end

  tdr_timers u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sfr_addr_in(addr),
    .sfr_wr_in(wr), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
    .ext_irq0_input_in(irq[0]), .ext_irq1_input_in(irq[1]),
    .irq0_polarity_in(pol[0]), .irq1_polarity_in(pol[1]),
    .count_pin_zero_in(cnt[0]), .count_pin_one_in(cnt[1]), .ext_clk_in(osc),
    .t0_vector_in(vec[0]), .t1_vector_in(vec[1]), .irq0_vector_in(vec[2]),
    .irq1_vector_in(vec[3]), .tmr2_split_in(t2c[0]), .tmr2_alt_clk_sel_in(t2c[1]),
    .t0_overflow_flag_out(flg_t[0]), .t1_overflow_flag_out(flg_t[1]),
    .ext_irq0_flag_out(flg_i[0]), .ext_irq1_flag_out(flg_i[1]),
    .tmr2_high_tick_out(t2h), .tmr2_low_tick_out(t2l));

  tdr_far_model u_far (.clk_in(clk_in), .irq_out(irq), .cnt_out(cnt), .vec_out(vec),
    .osc_out(osc));

  // ==========================================================
  // register access: one-cycle write strobe, read data one edge after the address
  task automatic wr_reg(input logic [7:0] ad, input logic [7:0] v);
    @(posedge clk_in);
    addr  <= ad;
    wr    <= 1'b1;
    wdata <= v;
    @(posedge clk_in);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] ad, output logic [7:0] v);
    @(posedge clk_in);
    addr <= ad;
    repeat (2) @(posedge clk_in);
    #1 v = rdata;
  endtask

  // let n edges pass and their updates land
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // hang guard, well above the few thousand cycles the tests need
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      results();
    end
  end

  // ==========================================================
  // test sequence
  initial begin
    repeat (16) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    // reset values, 0x8f unmapped
    for (i = 0; i < 8; i++) begin
      rd_reg(8'h88 + i[7:0], d);
      `CHK("reset value", 8'h00, d)
    end
    for (i = 0; i < 4; i++) begin
      wr_reg(`TDR_ADDR_T0LO + i[7:0], 8'ha5 + i[7:0]);
      rd_reg(`TDR_ADDR_T0LO + i[7:0], d);
      `CHK("count byte", 8'ha5 + i[7:0], d)
    end
    wr_reg(`TDR_ADDR_CLKC, 8'hff);
    rd_reg(`TDR_ADDR_CLKC, d);
    `CHK("clock control", 8'h3f, d)
    wr_reg(`TDR_ADDR_CLKC, 8'h10);
    settle(4);
    `CHK("t2 low tick", 1'b1, t2l)
    `CHK("t2 high tick", 1'b1, t2h)
    // split: high byte takes its own select; otherwise it follows the low select
    wr_reg(`TDR_ADDR_CLKC, 8'h20);
    @(posedge clk_in);
    t2c <= 2'b01;
    settle(4);
    `CHK("t2 split high tick", 1'b1, t2h)
    @(posedge clk_in);
    t2c <= 2'b00;
    i = 0;
    t = 0;
    repeat (24) begin
      @(posedge clk_in);
      #1;
      i += t2h;
      t += t2l;
    end
    `CHK("t2 high select ignored", 2, i)
    `CHK("t2 low over 12", 2, t)
    // irq flags in level then edge mode, active-high pins
    for (i = 0; i < 2; i++) begin
      @(posedge clk_in);
      pol[i] <= 1'b1;
      settle(8);
      `CHK("level flag", 1'b1, flg_i[i])
      wr_reg(`TDR_ADDR_CTRL, 8'h00);
      u_far.vector(i + 2, 1);
      settle(2);
      `CHK("level flag held", 1'b1, flg_i[i])
      u_far.set_irq(i, 1'b0);
      settle(8);
      wr_reg(`TDR_ADDR_CTRL, 8'h05);
      settle(2);
      `CHK("flag cleared", 1'b0, flg_i[i])
      u_far.set_irq(i, 1'b1);
      settle(8);
      `CHK("edge flag", 1'b1, flg_i[i])
      u_far.vector(i + 2, 2);
      settle(2);
      `CHK("edge flag vectored", 1'b0, flg_i[i])
      u_far.set_irq(i, 1'b0);
      wr_reg(`TDR_ADDR_CTRL, 8'h00);
    end
    // gate control, then pin counting with the clock select ignored
    for (t = 0; t < 2; t++) begin
      wr_reg(`TDR_ADDR_MODE, t ? 8'h90 : 8'h09);
      wr_reg(`TDR_ADDR_CLKC, 8'h0c);
      wr_reg(`TDR_ADDR_T0LO + t[7:0], 8'h00);
      wr_reg(`TDR_ADDR_CTRL, t ? 8'h40 : 8'h10);
      settle(20);
      rd_reg(`TDR_ADDR_T0LO + t[7:0], d);
      `CHK("gated count", 8'h00, d)
      u_far.set_irq(t, 1'b1);
      settle(20);
      rd_reg(`TDR_ADDR_T0LO + t[7:0], d);
      `CHK("gate open", 1'b1, d > 8'h05)
      u_far.set_irq(t, 1'b0);
      wr_reg(`TDR_ADDR_MODE, t ? 8'h50 : 8'h05);
      wr_reg(`TDR_ADDR_T0LO + t[7:0], 8'h00);
      u_far.pulse(t, 5, t + 2);
      settle(10);
      rd_reg(`TDR_ADDR_T0LO + t[7:0], d);
      `CHK("pin count", 8'h05, d)
      wr_reg(`TDR_ADDR_CTRL, 8'h00);
    end
    // 16-bit overflow on the system clock, vector clear, stop
    wr_reg(`TDR_ADDR_MODE, 8'h01);
    wr_reg(`TDR_ADDR_CLKC, 8'h04);
    wr_reg(`TDR_ADDR_T0LO, 8'hf0);
    wr_reg(`TDR_ADDR_T0HI, 8'hff);
    wr_reg(`TDR_ADDR_CTRL, 8'h10);
    settle(24);
    `CHK("t0 overflow", 1'b1, flg_t[0])
    u_far.vector(0, 3);
    settle(2);
    `CHK("t0 vectored", 1'b0, flg_t[0])
    wr_reg(`TDR_ADDR_CTRL, 8'h00);
    rd_reg(`TDR_ADDR_T0LO, a);
    settle(20);
    rd_reg(`TDR_ADDR_T0LO, d);
    `CHK("stopped count", a, d)
    // 8-bit reload
    wr_reg(`TDR_ADDR_T0HI, 8'h80);
    wr_reg(`TDR_ADDR_T0LO, 8'hfe);
    wr_reg(`TDR_ADDR_MODE, 8'h02);
    wr_reg(`TDR_ADDR_CTRL, 8'h10);
    settle(10);
    `CHK("reload overflow", 1'b1, flg_t[0])
    wr_reg(`TDR_ADDR_CTRL, 8'h00);
    settle(1);
    `CHK("software clear", 1'b0, flg_t[0])
    rd_reg(`TDR_ADDR_T0HI, d);
    `CHK("reload value", 8'h80, d)
    rd_reg(`TDR_ADDR_T0LO, d);
    `CHK("reloaded low", 1'b1, d[7])
    // 13-bit wrap from 0x1fff
    wr_reg(`TDR_ADDR_T0HI, 8'hff);
    wr_reg(`TDR_ADDR_T0LO, 8'hff);
    wr_reg(`TDR_ADDR_MODE, 8'h00);
    wr_reg(`TDR_ADDR_CTRL, 8'h10);
    settle(6);
    `CHK("13-bit overflow", 1'b1, flg_t[0])
    wr_reg(`TDR_ADDR_CTRL, 8'h00);
    rd_reg(`TDR_ADDR_T0LO, d);
    `CHK("low top bits", 3'b111, d[7:5])
    rd_reg(`TDR_ADDR_T0HI, d);
    `CHK("13-bit high", 8'h00, d)
    // split mode: high byte runs on timer 1 run bit and sets its flag
    wr_reg(`TDR_ADDR_MODE, 8'h03);
    wr_reg(`TDR_ADDR_T0HI, 8'hf0);
    wr_reg(`TDR_ADDR_T0LO, 8'h00);
    wr_reg(`TDR_ADDR_CTRL, 8'h40);
    settle(24);
    `CHK("split flag", 2'b10, flg_t)
    u_far.vector(1, 1);
    settle(2);
    `CHK("t1 vectored", 1'b0, flg_t[1])
    // timer 1 16-bit wrap on the system clock sets its own flag
    wr_reg(`TDR_ADDR_MODE, 8'h10);
    wr_reg(`TDR_ADDR_CLKC, 8'h08);
    wr_reg(`TDR_ADDR_T1HI, 8'hff);
    wr_reg(`TDR_ADDR_T1LO, 8'hf0);
    settle(24);
    `CHK("t1 overflow", 1'b1, flg_t[1])
    // timer 1 mode 3 holds still
    wr_reg(`TDR_ADDR_MODE, 8'h30);
    wr_reg(`TDR_ADDR_CLKC, 8'h08);
    wr_reg(`TDR_ADDR_T1LO, 8'h00);
    settle(20);
    rd_reg(`TDR_ADDR_T1LO, d);
    `CHK("t1 inactive", 8'h00, d)
    wr_reg(`TDR_ADDR_CTRL, 8'h00);
    // each prescale choice over 961 cycles, small slack for tick phase
    wr_reg(`TDR_ADDR_MODE, 8'h01);
    for (i = 0; i < 4; i++) begin
      wr_reg(`TDR_ADDR_CLKC, i[7:0]);
      wr_reg(`TDR_ADDR_T0LO, 8'h00);
      wr_reg(`TDR_ADDR_T0HI, 8'h00);
      wr_reg(`TDR_ADDR_CTRL, 8'h10);
      repeat (959) @(posedge clk_in);
      wr_reg(`TDR_ADDR_CTRL, 8'h00);
      rd_reg(`TDR_ADDR_T0LO, d);
      `CHK("prescaled count", 1'b1, (int'(d) >= exp_cnt[i] - 2 && int'(d) <= exp_cnt[i] + 2))
    end
    results();
  end
endmodule

`default_nettype wire
